// file: feature_pkg.sv
// constants for the power state and progress feature handler
// assumes a 200 MHz single clock and commands already decoded to feature id and dword 11
// Operation
// - feature id 11h selects the non-operational power state configuration word.
// - get of that configuration returns current settings in completion dword 0.
// - bit 0 is permissive mode enable; bits 31:1 reserved.
// - enable set lets background work exceed non-operational limits up to operational limits.
// - enable clear keeps background work within non-operational limits; work is deferred.
// - when disabled, power-using thermal management may stop; reduced performance after resume.
// - setting enable without advertised support fails with invalid field status.
// - feature id 80h selects the software progress marker word.
// - progress marker value is kept across every power state transition.
// - get of the progress marker returns it in completion dword 0.
// - bits 7:0 hold the pre-boot load count; bits 31:8 reserved.
package feature_pkg;
	localparam logic [7:0] FID_NONOP_POWER = 8'h11;
	localparam logic [7:0] FID_PROGRESS = 8'h80;
	localparam int PERMISSIVE_BIT = 0;
	localparam int LOAD_COUNT_LSB = 0;
	localparam int LOAD_COUNT_W = 8;
	localparam logic NONOP_RESET = 1'b0;
	localparam logic [7:0] LOAD_COUNT_RESET = 8'h00;
	localparam logic [7:0] STATUS_SUCCESS = 8'h00;
	localparam int CPL_LATENCY = 1;
endpackage

// file: feature_store.sv
// holds the two feature words, only their defined bits
// assumes writes are already validated by the command handler
`timescale 1ns/1ps
module feature_store #(
	parameter int COUNT_W = 8
) (
	// clock and control
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// write side
	input wire logic wr_nonop_in,
	input wire logic wr_progress_in,
	input wire logic [31:0] wdata_in,
	// stored values
	output logic permissive_out,
	output logic [COUNT_W-1:0] load_count_out
);
	import feature_pkg::*;

	logic permissive_reg, permissive_next;
	logic [COUNT_W-1:0] count_reg, count_next;

	always_comb begin
		permissive_next = permissive_reg;
		count_next = count_reg;
		if (wr_nonop_in) begin
			permissive_next = wdata_in[PERMISSIVE_BIT];
		end
		if (wr_progress_in) begin
			count_next = wdata_in[LOAD_COUNT_LSB +: COUNT_W];
		end
	end

	// no power state input here: the count survives every transition
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			permissive_reg <= NONOP_RESET;
			count_reg <= COUNT_W'(LOAD_COUNT_RESET);
		end else if (ce_in) begin
			permissive_reg <= permissive_next;
			count_reg <= count_next;
		end
	end

	assign permissive_out = permissive_reg;
	assign load_count_out = count_reg;
endmodule

// file: power_state_and_progress_features.sv
// set/get feature handler for non-operational power config and progress marker
// assumes one command per cycle at most, feature id and dword 11 already extracted
// every output is registered; a taken command completes on the next edge
`timescale 1ns/1ps
module power_state_and_progress_features #(
	parameter int COUNT_W = feature_pkg::LOAD_COUNT_W,
	parameter logic [7:0] STATUS_INVALID_FIELD = 8'h02
) (
	// clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// command request
	input wire logic cmd_valid_in,
	input wire logic cmd_is_set_in,
	input wire logic [7:0] cmd_fid_in,
	input wire logic [31:0] cmd_dw11_in,
	// controller capability
	input wire logic permissive_supported_in,
	// power and background activity
	input wire logic nonop_state_in,
	input wire logic bg_request_in,
	input wire logic bg_done_in,
	// completion
	output logic cpl_valid_out,
	output logic [31:0] cpl_dw0_out,
	output logic [7:0] cpl_status_out,
	// power policy
	output logic permissive_mode_enable_out,
	output logic bg_run_out,
	output logic bg_boost_out,
	output logic thermal_power_off_out,
	output logic reduced_perf_out
);
	import feature_pkg::*;

	typedef enum logic [2:0] {
		BG_IDLE = 3'b001,
		BG_DEFERRED = 3'b010,
		BG_CATCHUP = 3'b100
	} bg_state_t;

	function automatic logic fid_known(input logic [7:0] fid);
		fid_known = (fid == FID_NONOP_POWER) || (fid == FID_PROGRESS);
	endfunction

	// strict mode in a non-operational state: background work must wait
	function automatic logic strict_nonop(input logic nonop, input logic enable);
		strict_nonop = nonop && !enable;
	endfunction

	// enable bit asked for on a controller that cannot honour it
	function automatic logic enable_refused(input logic [31:0] dw11, input logic supported);
		enable_refused = dw11[PERMISSIVE_BIT] && !supported;
	endfunction

	// only defined fields are placed, so reserved bits always read as zero
	function automatic logic [31:0] nonop_word(input logic enable);
		nonop_word = 32'h0000_0000;
		nonop_word[PERMISSIVE_BIT] = enable;
	endfunction

	function automatic logic [31:0] progress_word(input logic [COUNT_W-1:0] count);
		progress_word = 32'h0000_0000;
		progress_word[LOAD_COUNT_LSB +: COUNT_W] = count;
	endfunction

	logic permissive;
	logic [COUNT_W-1:0] load_count;
	logic wr_nonop, wr_progress, reject;

	// command group
	logic cpl_valid_reg, cpl_valid_next;
	logic [31:0] cpl_dw0_reg, cpl_dw0_next;
	logic [7:0] cpl_status_reg, cpl_status_next;

	// policy group
	bg_state_t bg_state_reg, bg_state_next;
	logic bg_run_reg, bg_run_next;
	logic bg_boost_reg, bg_boost_next;
	logic thermal_off_reg, thermal_off_next;
	logic reduced_reg, reduced_next;
	// copy of the stored enable, one cycle behind the store
	logic perm_reg, perm_next;

	// command decode and completion
	always_comb begin
		reject = 1'b0;
		wr_nonop = 1'b0;
		wr_progress = 1'b0;
		cpl_valid_next = 1'b0;
		cpl_dw0_next = 32'h0000_0000;
		cpl_status_next = STATUS_SUCCESS;
		if (cmd_valid_in) begin
			cpl_valid_next = 1'b1;
			if (!fid_known(cmd_fid_in)) begin
				reject = 1'b1;
			end else if (cmd_fid_in == FID_NONOP_POWER) begin
				if (cmd_is_set_in) begin
					// enable without support refuses the whole write
					reject = enable_refused(cmd_dw11_in, permissive_supported_in);
					wr_nonop = !reject;
				end else begin
					cpl_dw0_next = nonop_word(permissive);
				end
			end else begin
				if (cmd_is_set_in) begin
					// count policy belongs to host software; store as written
					wr_progress = 1'b1;
				end else begin
					cpl_dw0_next = progress_word(load_count);
				end
			end

			// a refused command still completes, with zero data
			if (reject) begin
				cpl_status_next = STATUS_INVALID_FIELD;
			end
		end
	end

	// background work policy in non-operational states
	always_comb begin
		bg_state_next = bg_state_reg;
		perm_next = permissive;
		bg_run_next = 1'b0;
		bg_boost_next = 1'b0;
		thermal_off_next = strict_nonop(nonop_state_in, permissive);

		case (bg_state_reg)
			BG_IDLE: begin
				if (bg_request_in && strict_nonop(nonop_state_in, permissive)) begin
					bg_state_next = BG_DEFERRED;
				end
			end
			BG_DEFERRED: begin
				// held-back work waits for the resume, or for permission
				if (!nonop_state_in) begin
					bg_state_next = BG_CATCHUP;
				end else if (permissive) begin
					bg_state_next = BG_IDLE;
				end
			end
			BG_CATCHUP: begin
				// falling asleep again before catch-up ends defers the rest
				if (bg_done_in) begin
					bg_state_next = BG_IDLE;
				end else if (nonop_state_in) begin
					bg_state_next = BG_DEFERRED;
				end
			end
			default: begin
				bg_state_next = BG_IDLE;
			end
		endcase

		// run permission follows the request with one cycle of latency
		if (bg_request_in) begin
			if (!nonop_state_in) begin
				bg_run_next = 1'b1;
			end else if (permissive) begin
				bg_run_next = 1'b1;
				bg_boost_next = 1'b1;
			end
		end

		// taken from the next state so the flag rises with the resume
		reduced_next = (bg_state_next == BG_CATCHUP);
	end

	// command group registers
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cpl_valid_reg <= 1'b0;
			cpl_dw0_reg <= 32'h0000_0000;
			cpl_status_reg <= STATUS_SUCCESS;
		end else if (ce_in) begin
			cpl_valid_reg <= cpl_valid_next;
			cpl_dw0_reg <= cpl_dw0_next;
			cpl_status_reg <= cpl_status_next;
		end
	end

	// policy group registers; a low enable freezes them with the rest
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			bg_state_reg <= BG_IDLE;
			bg_run_reg <= 1'b0;
			bg_boost_reg <= 1'b0;
			thermal_off_reg <= 1'b0;
			reduced_reg <= 1'b0;
			perm_reg <= NONOP_RESET;
		end else if (ce_in) begin
			bg_state_reg <= bg_state_next;
			bg_run_reg <= bg_run_next;
			bg_boost_reg <= bg_boost_next;
			thermal_off_reg <= thermal_off_next;
			reduced_reg <= reduced_next;
			perm_reg <= perm_next;
		end
	end

	// storage kept apart so only a taken set or reset can touch it
	feature_store #(
		.COUNT_W(COUNT_W)
	) u_store (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.wr_nonop_in(wr_nonop),
		.wr_progress_in(wr_progress),
		.wdata_in(cmd_dw11_in),
		.permissive_out(permissive),
		.load_count_out(load_count)
	);

	// every output straight from its flop
	assign cpl_valid_out = cpl_valid_reg;
	assign cpl_dw0_out = cpl_dw0_reg;
	assign cpl_status_out = cpl_status_reg;
	assign permissive_mode_enable_out = perm_reg;
	assign bg_run_out = bg_run_reg;
	assign bg_boost_out = bg_boost_reg;
	assign thermal_power_off_out = thermal_off_reg;
	assign reduced_perf_out = reduced_reg;
endmodule

// file: feature_props.sv
// port checker for the feature handler
// assumes a command is taken only with ce_in high; attempts meeting a frozen cycle are dropped
`timescale 1ns/1ps
module feature_props import feature_pkg::*; #(parameter logic [7:0] STATUS_INVALID_FIELD = 8'h02) (
	input wire logic clk_sys_in, sys_rst_in, ce_in, cmd_valid_in, cmd_is_set_in, permissive_supported_in,
	input wire logic [7:0] cmd_fid_in, cpl_status_out,
	input wire logic [31:0] cmd_dw11_in, cpl_dw0_out,
	input wire logic nonop_state_in, cpl_valid_out, permissive_mode_enable_out, bg_boost_out, thermal_power_off_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in || !ce_in);
	sequence bad_fid;
		cmd_valid_in && cmd_fid_in != FID_NONOP_POWER && cmd_fid_in != FID_PROGRESS;
	endsequence
	// accepted set of the config word, with no second one behind it
	sequence ok_nonop;
		cmd_valid_in && cmd_is_set_in && cmd_fid_in == FID_NONOP_POWER && (permissive_supported_in || !cmd_dw11_in[0])
		##1 !(cmd_valid_in && cmd_fid_in == FID_NONOP_POWER);
	endsequence
	a_cpl_one_cycle: assert property (cmd_valid_in |=> cpl_valid_out) else $error("completion missing");
	a_no_stray_cpl: assert property (!cmd_valid_in |=> !cpl_valid_out) else $error("stray completion");
	a_bad_fid_refused: assert property (bad_fid |=> cpl_status_out == STATUS_INVALID_FIELD && cpl_dw0_out == 0)
		else $error("unknown feature accepted");
	a_refuse_perm_set: assert property (cmd_valid_in && cmd_is_set_in && cmd_fid_in == FID_NONOP_POWER && cmd_dw11_in[0]
		&& !permissive_supported_in |=> cpl_status_out == STATUS_INVALID_FIELD) else $error("enable not refused");
	a_perm_needs_cap: assert property ($rose(permissive_mode_enable_out) |-> $past(permissive_supported_in, 2))
		else $error("enable set without support");
	a_set_follows_bit: assert property (ok_nonop |=> permissive_mode_enable_out == $past(cmd_dw11_in[0], 2))
		else $error("enable not stored");
	a_reserved_zero: assert property (cpl_valid_out |-> cpl_dw0_out[31:8] == 24'h00_0000)
		else $error("reserved bits set");
	a_thermal_off: assert property ((nonop_state_in && !permissive_mode_enable_out && !cmd_valid_in) [*2]
		|=> thermal_power_off_out) else $error("thermal not off");
	a_no_boost: assert property ((!permissive_mode_enable_out && !cmd_valid_in) [*2] |=> !bg_boost_out)
		else $error("boost while strict");
endmodule
bind power_state_and_progress_features feature_props #(.STATUS_INVALID_FIELD(STATUS_INVALID_FIELD)) props_u (
	.clk_sys_in, .sys_rst_in, .ce_in, .cmd_valid_in, .cmd_is_set_in, .permissive_supported_in, .cmd_fid_in,
	.cpl_status_out, .cmd_dw11_in, .cpl_dw0_out, .nonop_state_in, .cpl_valid_out, .permissive_mode_enable_out,
	.bg_boost_out, .thermal_power_off_out);

// file: power_state_and_progress_features_tb.sv
// self-checking bench for the feature handler
// assumes one 200 MHz clock; ce_in stays high except for the one frozen-cycle check near the end
`timescale 1ns/1ps
module power_state_and_progress_features_tb;
	import feature_pkg::*;
	// non-default refusal code proves the parameter is really used
	localparam logic [7:0] BAD = 8'h03;
	logic clk_sys_in = 0, sys_rst_in = 1, ce_in = 1, cmd_valid_in = 0, cmd_is_set_in = 0, m_perm = 0;
	logic permissive_supported_in = 0, nonop_state_in = 0, bg_request_in = 0, bg_done_in = 0;
	logic [7:0] cmd_fid_in = 0, cpl_status_out, m_cnt = 0;
	logic [7:0] fids [3] = '{FID_NONOP_POWER, FID_PROGRESS, 8'h81};
	logic [31:0] cmd_dw11_in = 0, cpl_dw0_out;
	logic cpl_valid_out, permissive_mode_enable_out, bg_run_out, bg_boost_out, thermal_power_off_out, reduced_perf_out;
	int err_total = 0, total_checks = 0, seed = 55;
	always #2.5 clk_sys_in = ~clk_sys_in;
	power_state_and_progress_features #(.STATUS_INVALID_FIELD(BAD)) dut_u (.clk_sys_in, .sys_rst_in, .ce_in,
		.cmd_valid_in, .cmd_is_set_in, .cmd_fid_in, .cmd_dw11_in, .permissive_supported_in, .nonop_state_in,
		.bg_request_in, .bg_done_in, .cpl_valid_out, .cpl_dw0_out, .cpl_status_out, .permissive_mode_enable_out,
		.bg_run_out, .bg_boost_out, .thermal_power_off_out, .reduced_perf_out);
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	function logic [7:0] exp_status(input logic s, input logic [7:0] f, input logic b0);
		if (f != FID_NONOP_POWER && f != FID_PROGRESS) return BAD;
		return (s && f == FID_NONOP_POWER && b0 && !permissive_supported_in) ? BAD : STATUS_SUCCESS;
	endfunction
	// host boot policy: one more per successful load, held once at the top
	function logic [7:0] boot_count(input logic [7:0] c);
		return (c == 8'hFF) ? c : c + 8'h01;
	endfunction
	// valid is left high so calls run back to back
	task op(input logic s, input logic [7:0] f, input logic [31:0] d);
		logic [7:0] st;
		logic [31:0] e;
		st = exp_status(s, f, d[0]);
		e = 0;
		if (!s && st == 0) e = (f == FID_PROGRESS) ? {24'h00_0000, m_cnt} : {31'h0, m_perm};
		if (s && st == 0 && f == FID_NONOP_POWER) m_perm = d[0];
		if (s && st == 0 && f == FID_PROGRESS) m_cnt = d[7:0];
		{cmd_valid_in, cmd_is_set_in, cmd_fid_in, cmd_dw11_in} = {1'b1, s, f, d};
		@(posedge clk_sys_in);
		#1;
		chk("cpl_valid", 1, cpl_valid_out);
		chk("status", st, cpl_status_out);
		chk("dw0", e, cpl_dw0_out);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk_sys_in);
		#1 sys_rst_in = 0;
		op(0, FID_NONOP_POWER, 0);
		op(0, FID_PROGRESS, 0);
		$display("reset values done");
		for (int p = 0; p < 2; p++) begin
			permissive_supported_in = p[0];
			op(1, FID_NONOP_POWER, 1);
			for (int i = 0; i < 150; i++) begin
				nonop_state_in = 1'($random(seed));
				op(1'($random(seed)), fids[$unsigned($random(seed)) % 3], $random(seed));
			end
		end
		op(1, FID_PROGRESS, 32'hFFFF_FFFF);
		op(1, FID_PROGRESS, {24'h00_0000, boot_count(m_cnt)});
		op(0, FID_PROGRESS, 0);
		op(1, FID_PROGRESS, 0);
		op(1, FID_PROGRESS, {24'h00_0000, boot_count(m_cnt)});
		op(0, FID_PROGRESS, 0);
		op(1, FID_NONOP_POWER, 1);
		cmd_valid_in = 0;
		{nonop_state_in, bg_request_in} = 2'b11;
		repeat (2) @(posedge clk_sys_in);
		#1 chk("perm_enable", 1, permissive_mode_enable_out);
		chk("bg_boost", 1, bg_boost_out);
		chk("bg_run", 1, bg_run_out);
		chk("thermal", 0, thermal_power_off_out);
		op(1, FID_NONOP_POWER, 0);
		cmd_valid_in = 0;
		$display("commands done");
		repeat (3) @(posedge clk_sys_in);
		#1 chk("thermal", 1, thermal_power_off_out);
		chk("bg_run", 0, bg_run_out);
		chk("perm_enable", 0, permissive_mode_enable_out);
		chk("bg_boost", 0, bg_boost_out);
		nonop_state_in = 0;
		@(posedge clk_sys_in);
		#1 chk("reduced_perf", 1, reduced_perf_out);
		bg_done_in = 1;
		repeat (2) @(posedge clk_sys_in);
		#1 chk("reduced_perf", 0, reduced_perf_out);
		$display("policy done");
		ce_in = 0;
		{cmd_valid_in, cmd_is_set_in, cmd_fid_in, cmd_dw11_in} = {1'b1, 1'b1, FID_PROGRESS, 32'h0000_00A5};
		repeat (2) @(posedge clk_sys_in);
		#1 chk("frozen_cpl", 0, cpl_valid_out);
		ce_in = 1;
		op(0, FID_PROGRESS, 0);
		$display("enable done");
		summarize;
	end
	initial begin
		#20000;
		err_total++;
		summarize;
	end
endmodule
